// ===== logic/dpcsr_regs.sv
// dpcsr_regs: control/status register bank of the single-wire debug port
// assumes the port instruction decoder and phy run on sys_clk_i, the port clock
`timescale 1ns/1ps
module dpcsr_regs (
  // clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  // port instruction access (debugger only)
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic      [7:0]             reg_rdata_o,
  // phy error events
  input  wire logic                   err_parity_i,
  input  wire logic                   err_frame_i,
  input  wire logic                   err_clkrec_i,
  input  wire logic                   err_contend_i,
  // phy and access layer handshake
  input  wire logic                   acc_wait_i,
  input  wire logic                   acc_resp_i,
  input  wire logic                   tx_req_i,
  input  wire logic                   tx_multi_i,
  input  wire logic                   tx_ack_req_i,
  input  wire logic                   tx_nack_req_i,
  input  wire logic                   ldst_busy_i,
  // key events from key decoder and nvm
  input  wire logic                   key_urow_i,
  input  wire logic                   key_prog_i,
  input  wire logic                   key_erase_i,
  input  wire logic                   prog_done_i,
  input  wire logic                   erase_done_i,
  // system status (from system domain)
  input  wire logic                   sys_asleep_i,
  input  wire logic                   sys_in_reset_i,
  input  wire logic                   lock_i,
  input  wire logic                   urow_ready_i,
  input  wire logic                   prog_ready_i,
  input  wire logic [2:0]             crc_status_i,
  // phy controls
  output logic                        parity_check_disable_o,
  output logic                        contention_detect_disable_o,
  output logic                        tx_start_o,
  output logic                        sig_send_o,
  output logic                        timeout_o,
  output logic                        port_reset_o,
  // system controls
  output logic                        system_reset_o,
  output logic                        system_clock_request_o,
  output logic [1:0]                  port_clock_select_o,
  output logic                        user_row_commit_o
);
  import dpcsr_pkg::*;

  typedef enum logic [1:0] {
    DPCSR_TX_IDLE = 2'b00,
    DPCSR_TX_WAIT = 2'b01,
    DPCSR_TX_GO   = 2'b10
  } dpcsr_tx_t;

  typedef struct packed {
    logic [7:0]  ctla;
    logic [2:0]  ctlb;
    logic [2:0]  err;
    logic [2:0]  keys;
    logic        rst;
    logic        system_clock_request;
    logic [1:0]  clksel;
    logic        commit;
    logic [16:0] tocnt;
    logic        timeout;
    dpcsr_tx_t   txst;
    logic [7:0]  gcnt;
    logic        tx_start;
    logic        sig_send;
    logic        prst;
    logic [7:0]  rdata;
    logic        sync_a1;
    logic        sync_a2;
    logic        sync_r1;
    logic        sync_r2;
  } dpcsr_state_t;

  dpcsr_state_t state_reg;
  dpcsr_state_t state_next;
  logic [7:0]   gt_len;
  logic [7:0]   gap_len;
  logic [2:0]   err_code;
  logic         err_any;
  logic [7:0]   rd_mux;

  // guard time length from select code
  always_comb
  begin
    case (state_reg.ctla[2:0])
      3'h0:    gt_len = DPCSR_GT_MAX;
      3'h1:    gt_len = 8'h40;
      3'h2:    gt_len = 8'h20;
      3'h3:    gt_len = 8'h10;
      3'h4:    gt_len = 8'h08;
      3'h5:    gt_len = 8'h04;
      3'h6:    gt_len = 8'h02;
      default: gt_len = 8'h00;
    endcase
  end

  assign gap_len = 8'(DPCSR_GAP_CHARS) * {4'h0, DPCSR_CHAR_BITS};

  // error priority: contention strongest, reserved codes never produced
  always_comb
  begin
    err_any  = 1'b1;
    err_code = DPCSR_ERR_NONE;
    if (err_contend_i && !state_reg.ctlb[DPCSR_B_CCD - 2])
      err_code = DPCSR_ERR_CONTEND;
    else if (err_clkrec_i)
      err_code = DPCSR_ERR_CLKREC;
    else if (state_reg.timeout)
      err_code = DPCSR_ERR_TIMEOUT;
    else if (err_frame_i)
      err_code = DPCSR_ERR_FRAME;
    else if (err_parity_i && !state_reg.ctla[DPCSR_A_PARITY_CHECK_DISABLE])
      err_code = DPCSR_ERR_PARITY;
    else
      err_any = 1'b0;
  end

  // read mux; only the system-in-reset input is read after the synchroniser, other system inputs directly
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      DPCSR_OFS_REV:    rd_mux = {DPCSR_REVISION, 4'h0};
      DPCSR_OFS_ERR:    rd_mux = {5'h00, state_reg.err};
      DPCSR_OFS_CTLA:   rd_mux = {state_reg.ctla[7], 1'b0, state_reg.ctla[5:0]};
      DPCSR_OFS_CTLB:   rd_mux = {3'h0, state_reg.ctlb, 2'h0};
      DPCSR_OFS_KEY:    rd_mux = {2'h0, state_reg.keys, 3'h0};
      DPCSR_OFS_RST:    rd_mux = {7'h00, state_reg.rst};
      DPCSR_OFS_CLKSEL: rd_mux = {6'h00, state_reg.clksel};
      DPCSR_OFS_SYSCTL: rd_mux = {6'h00, state_reg.commit, state_reg.system_clock_request};
      DPCSR_OFS_SYSST:  rd_mux = {2'h0, state_reg.sync_r2, sys_asleep_i, prog_ready_i,
                                  urow_ready_i, 1'b0, lock_i};
      DPCSR_OFS_CRC:    rd_mux = {5'h00, crc_status_i};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    state_next          = state_reg;
    state_next.tx_start = 1'b0;
    state_next.sig_send = 1'b0;
    state_next.commit   = 1'b0;
    state_next.prst     = 1'b0;
    state_next.sync_a1  = acc_wait_i;
    state_next.sync_a2  = state_reg.sync_a1;
    state_next.sync_r1  = sys_in_reset_i;
    state_next.sync_r2  = state_reg.sync_r1;
    // reads come only from port instructions; no cpu path exists
    if (reg_rd_i)
      state_next.rdata = rd_mux;
    // access layer time-out
    // any answer restarts the count, so an access layer answering within every 65536 cycles never times out
    state_next.timeout = 1'b0;
    if (state_reg.sync_a2 && !acc_resp_i && !state_reg.ctla[DPCSR_A_TOD])
    begin
      if (state_reg.tocnt == 17'(DPCSR_TIMEOUT_CYC - 1))
      begin
        state_next.timeout = 1'b1;
        state_next.tocnt   = 17'h00000;
      end
      else
        state_next.tocnt = state_reg.tocnt + 17'h00001;
    end
    else
      state_next.tocnt = 17'h00000;
    // error field: a read clears, a new error in the same cycle wins
    if (reg_rd_i && reg_addr_i == DPCSR_OFS_ERR)
      state_next.err = DPCSR_ERR_NONE;
    if (err_any)
      state_next.err = err_code;
    // key auto-clear, then new activations win
    if (prog_done_i)
      state_next.keys[DPCSR_K_PROG - 3] = 1'b0;
    if (erase_done_i)
      state_next.keys[DPCSR_K_ERASE - 3] = 1'b0;
    if (key_urow_i)
      state_next.keys[DPCSR_K_UROW - 3] = 1'b1;
    if (key_prog_i)
      state_next.keys[DPCSR_K_PROG - 3] = 1'b1;
    if (key_erase_i)
      state_next.keys[DPCSR_K_ERASE - 3] = 1'b1;
    // transmit pacing: guard time first, then the inter-byte gap
    // two clocks of state overhead on top of every guard or gap count
    case (state_reg.txst)
      DPCSR_TX_IDLE:
      begin
        if (tx_req_i)
        begin
          state_next.gcnt = gt_len;
          state_next.txst = DPCSR_TX_WAIT;
        end
      end
      DPCSR_TX_WAIT:
      begin
        if (state_reg.gcnt == 8'h00)
          state_next.txst = DPCSR_TX_GO;
        else
          state_next.gcnt = state_reg.gcnt - 8'h01;
      end
      DPCSR_TX_GO:
      begin
        state_next.tx_start = 1'b1;
        if (tx_multi_i && state_reg.ctla[DPCSR_A_GAP])
        begin
          state_next.gcnt = gap_len;
          state_next.txst = DPCSR_TX_WAIT;
        end
        else if (tx_multi_i)
          state_next.txst = DPCSR_TX_GO;
        else
          state_next.txst = DPCSR_TX_IDLE;
      end
      default: state_next.txst = DPCSR_TX_IDLE;
    endcase
    // response signatures
    if (tx_ack_req_i && !state_reg.ctla[DPCSR_A_RSD])
      state_next.sig_send = 1'b1;
    if (tx_nack_req_i && !state_reg.ctla[DPCSR_A_RSD]
        && !(state_reg.ctlb[DPCSR_B_NACKD - 2] && ldst_busy_i && state_reg.sync_r2))
      state_next.sig_send = 1'b1;
    // register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        DPCSR_OFS_CTLA:   state_next.ctla = reg_wdata_i & 8'hBF;
        DPCSR_OFS_CTLB:   state_next.ctlb = reg_wdata_i[4:2];
        DPCSR_OFS_KEY:    if (reg_wdata_i[DPCSR_K_UROW])
                            state_next.keys[DPCSR_K_UROW - 3] = 1'b0;
        DPCSR_OFS_RST:    state_next.rst = (reg_wdata_i == DPCSR_RST_SIG);
        DPCSR_OFS_CLKSEL: state_next.clksel = reg_wdata_i[1:0];
        DPCSR_OFS_SYSCTL:
        begin
          state_next.system_clock_request = reg_wdata_i[0];
          state_next.commit = reg_wdata_i[1] & state_reg.keys[DPCSR_K_UROW - 3];
        end
        default: state_next.rdata = state_next.rdata;
      endcase
    end
    // port disable: controls, keys, error, tx state and clock select back to reset; clock request cleared, reset request kept
    if (state_reg.ctlb[DPCSR_B_DIS - 2])
    begin
      state_next.ctla   = DPCSR_CTL_RST;
      state_next.ctlb   = 3'h0;
      state_next.keys   = 3'h0;
      state_next.system_clock_request = 1'b0;
      state_next.err    = DPCSR_ERR_NONE;
      state_next.txst   = DPCSR_TX_IDLE;
      state_next.clksel = DPCSR_CLKSEL_RST;
      state_next.prst   = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_reg        <= '0;
      state_reg.system_clock_request <= 1'b1;
      state_reg.clksel <= DPCSR_CLKSEL_RST;
      state_reg.txst   <= DPCSR_TX_IDLE;
    end
    else
      state_reg <= state_next;
  end

  assign reg_rdata_o                 = state_reg.rdata;
  assign parity_check_disable_o      = state_reg.ctla[DPCSR_A_PARITY_CHECK_DISABLE];
  assign contention_detect_disable_o = state_reg.ctlb[DPCSR_B_CCD - 2];
  assign tx_start_o                  = state_reg.tx_start;
  assign sig_send_o                  = state_reg.sig_send;
  assign timeout_o                   = state_reg.timeout;
  assign port_reset_o                = state_reg.prst;
  assign system_reset_o              = state_reg.rst;
  assign system_clock_request_o      = state_reg.system_clock_request;
  assign port_clock_select_o         = state_reg.clksel;
  assign user_row_commit_o           = state_reg.commit;

  // assertions
  a_err_no_reserved: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.err != 3'h5 && state_reg.err != 3'h6)
    else $error("reserved error code loaded");
  a_err_read_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == DPCSR_OFS_ERR && !err_any && !state_reg.ctlb[0]
    |=> state_reg.err == DPCSR_ERR_NONE)
    else $error("error field not cleared by read");
  a_contend_code: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    err_contend_i && !state_reg.ctlb[1] && !state_reg.ctlb[0] |=> state_reg.err == 3'h7)
    else $error("contention code missing");
  a_parity_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.ctla[5] && state_reg.err != 3'h1 |=> state_reg.err != 3'h1)
    else $error("parity error with check disabled");
  a_rst_sig: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == DPCSR_OFS_RST |=> system_reset_o == ($past(reg_wdata_i) == 8'h59))
    else $error("reset request mismatch");
  a_disable_clr: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.ctlb[0] |=> state_reg.keys == 3'h0 && !system_clock_request_o && port_reset_o)
    else $error("disable did not clear state");
  a_rsd_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.ctla[3] && !(reg_wr_i && reg_addr_i == DPCSR_OFS_CTLA) |=> !sig_send_o)
    else $error("signature sent while disabled");
  a_gt_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.txst == DPCSR_TX_IDLE && tx_req_i && state_reg.ctla[2:0] == 3'h6
    && !state_reg.ctlb[0] |=> !tx_start_o [*4] ##1 tx_start_o)
    else $error("guard time wrong");
  a_prog_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    prog_done_i && !key_prog_i |=> !state_reg.keys[1])
    else $error("programming key not cleared");
  a_erase_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    erase_done_i && !key_erase_i |=> !state_reg.keys[0])
    else $error("erase key not cleared");
  a_timeout_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.ctla[DPCSR_A_TOD] |=> !timeout_o)
    else $error("time-out flagged while detection disabled");
  a_timeout_err: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    timeout_o && !err_clkrec_i && !(err_contend_i && !state_reg.ctlb[1])
    && !state_reg.ctlb[0] |=> state_reg.err == DPCSR_ERR_TIMEOUT)
    else $error("time-out code missing");
  a_ccd_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    state_reg.ctlb[1] && state_reg.err != 3'h7 |=> state_reg.err != 3'h7)
    else $error("contention loaded while detection disabled");
  a_nack_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_nack_req_i && !tx_ack_req_i && state_reg.ctlb[2] && ldst_busy_i
    && state_reg.sync_r2 |=> !sig_send_o)
    else $error("negative acknowledge sent during system reset");
  a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && (reg_addr_i > DPCSR_OFS_CRC
    || (reg_addr_i >= DPCSR_OFS_ALO && reg_addr_i < DPCSR_OFS_KEY))
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped offset read nonzero");
  a_rst_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    system_reset_o && !(reg_wr_i && reg_addr_i == DPCSR_OFS_RST) |=> system_reset_o)
    else $error("system reset dropped without a write");
  c_nack_hold: cover property (@(posedge sys_clk_i)
    tx_nack_req_i && state_reg.sync_r2 && ldst_busy_i);
  c_timeout: cover property (@(posedge sys_clk_i) timeout_o);
  c_gap: cover property (@(posedge sys_clk_i) tx_start_o ##[1:40] tx_start_o);
  c_reset_req: cover property (@(posedge sys_clk_i) $rose(system_reset_o));
endmodule : dpcsr_regs

// ===== logic/dpcsr_pkg.sv
// dpcsr_pkg: offsets, field positions, reset values and timing for the debug port register bank
// assumes an 8-bit register space reached only by the port instruction decoder
package dpcsr_pkg;
  // register offsets
  localparam logic [3:0] DPCSR_OFS_REV    = 4'h0;
  localparam logic [3:0] DPCSR_OFS_ERR    = 4'h1;
  localparam logic [3:0] DPCSR_OFS_CTLA   = 4'h2;
  localparam logic [3:0] DPCSR_OFS_CTLB   = 4'h3;
  localparam logic [3:0] DPCSR_OFS_ALO    = 4'h4;
  localparam logic [3:0] DPCSR_OFS_PHYHI  = 4'h3;
  localparam logic [3:0] DPCSR_OFS_KEY    = 4'h7;
  localparam logic [3:0] DPCSR_OFS_RST    = 4'h8;
  localparam logic [3:0] DPCSR_OFS_CLKSEL = 4'h9;
  localparam logic [3:0] DPCSR_OFS_SYSCTL = 4'hA;
  localparam logic [3:0] DPCSR_OFS_SYSST  = 4'hB;
  localparam logic [3:0] DPCSR_OFS_CRC    = 4'hC;
  // revision code; value is arbitrary
  localparam logic [3:0] DPCSR_REVISION   = 4'h2;
  // error signatures
  localparam logic [2:0] DPCSR_ERR_NONE    = 3'h0;
  localparam logic [2:0] DPCSR_ERR_PARITY  = 3'h1;
  localparam logic [2:0] DPCSR_ERR_FRAME   = 3'h2;
  localparam logic [2:0] DPCSR_ERR_TIMEOUT = 3'h3;
  localparam logic [2:0] DPCSR_ERR_CLKREC  = 3'h4;
  localparam logic [2:0] DPCSR_ERR_CONTEND = 3'h7;
  // control, key and status field positions
  localparam int DPCSR_A_GAP   = 7;
  localparam int DPCSR_A_PARITY_CHECK_DISABLE  = 5;
  localparam int DPCSR_A_TOD   = 4;
  localparam int DPCSR_A_RSD   = 3;
  localparam int DPCSR_B_NACKD = 4;
  localparam int DPCSR_B_CCD   = 3;
  localparam int DPCSR_B_DIS   = 2;
  localparam int DPCSR_K_UROW  = 5;
  localparam int DPCSR_K_PROG  = 4;
  localparam int DPCSR_K_ERASE = 3;
  localparam int DPCSR_S_SYSTEM_IN_RESET = 5;
  localparam int DPCSR_S_SLEEP  = 4;
  localparam int DPCSR_S_PROG   = 3;
  localparam int DPCSR_S_UROW   = 2;
  // reset values, reset request signature and guard-time-off code
  localparam logic [7:0] DPCSR_CTL_RST    = 8'h00;
  localparam logic [1:0] DPCSR_CLKSEL_RST = 2'h3;
  localparam logic [7:0] DPCSR_RST_SIG    = 8'h59;
  localparam logic [2:0] DPCSR_GT_OFF     = 3'h7;
  // timing
  localparam int unsigned DPCSR_TIMEOUT_CYC = 65536;
  localparam int unsigned DPCSR_GAP_CHARS   = 2;
  localparam logic [7:0]  DPCSR_GT_MAX      = 8'h80;
  localparam logic [3:0]  DPCSR_CHAR_BITS   = 4'hC;
endpackage : dpcsr_pkg

// ===== bench/dpcsr_acc_model.sv
// dpcsr_acc_model: access layer stand-in that answers the phy's wait requests
// assumes acc_wait_i of the bench feeds acc_wait_i here, same port clock
`timescale 1ns/1ps
module dpcsr_acc_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // handshake
  input  wire logic acc_wait_i,
  input  wire logic hang_i,
  output logic      acc_resp_o
);
  int cnt;

  // hang stands for a sleeping or reset system domain: no answer at all
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !acc_wait_i || hang_i)
    begin
      cnt        <= 0;
      acc_resp_o <= 1'b0;
    end
    else
    begin
      cnt        <= (cnt == DELAY) ? 0 : cnt + 1;
      acc_resp_o <= (cnt == DELAY);
    end
  end
endmodule : dpcsr_acc_model

// ===== bench/dpcsr_regs_tb.sv
// dpcsr_regs_tb: self-checking bench for the debug port register bank
// assumes dpcsr_pkg compiled first; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got %0h exp %0h", $time, got, exp); end end
module dpcsr_regs_tb;
  import dpcsr_pkg::*;
  typedef struct {logic w; logic [3:0] a; logic [7:0] v;} dpcsr_row_t;
  logic       sys_clk_i, reset_i, reg_wr_i, reg_rd_i, acc_wait_i, acc_resp_i, hang;
  logic [3:0] reg_addr_i, ev;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [11:0] pv;
  logic       tx_multi_i, ldst_busy_i, sys_asleep_i, sys_in_reset_i, lock_i;
  logic       urow_ready_i, prog_ready_i, parity_check_disable_o, contention_detect_disable_o;
  logic       tx_start_o, sig_send_o, timeout_o, port_reset_o, system_reset_o;
  logic       system_clock_request_o, user_row_commit_o;
  logic [2:0] crc_status_i;
  logic [1:0] port_clock_select_o;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  int         miscompares, compares, cyc, n;
  // writes have no read-back here; the following read row checks them
  dpcsr_row_t rows [$] = '{'{0, 4'h0, 8'h20}, '{1, 4'h0, 8'hFF}, '{0, 4'h0, 8'h20},
    '{0, 4'h1, 8'h00}, '{0, 4'h2, 8'h00}, '{1, 4'h2, 8'hBF}, '{0, 4'h2, 8'hBF},
    '{1, 4'h2, 8'h06}, '{0, 4'h2, 8'h06}, '{0, 4'h3, 8'h00}, '{1, 4'h3, 8'h18},
    '{0, 4'h3, 8'h18}, '{1, 4'h5, 8'hFF}, '{0, 4'h5, 8'h00}, '{0, 4'h4, 8'h00},
    '{0, 4'h6, 8'h00}, '{1, 4'hD, 8'h5A}, '{0, 4'hD, 8'h00}, '{0, 4'h7, 8'h00},
    '{0, 4'h8, 8'h00}, '{0, 4'h9, 8'h03}, '{1, 4'h9, 8'h01}, '{0, 4'h9, 8'h01}};

  assign ev = {port_reset_o, timeout_o, sig_send_o, tx_start_o};

  dpcsr_regs dpcsr_regs_inst (
    .sys_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .err_parity_i(pv[0]), .err_frame_i(pv[1]), .err_clkrec_i(pv[2]), .err_contend_i(pv[3]),
    .acc_wait_i, .acc_resp_i, .tx_req_i(pv[9]), .tx_multi_i, .tx_ack_req_i(pv[10]),
    .tx_nack_req_i(pv[11]), .ldst_busy_i, .key_urow_i(pv[4]), .key_prog_i(pv[5]),
    .key_erase_i(pv[6]), .prog_done_i(pv[7]), .erase_done_i(pv[8]), .sys_asleep_i,
    .sys_in_reset_i, .lock_i, .urow_ready_i, .prog_ready_i, .crc_status_i,
    .parity_check_disable_o, .contention_detect_disable_o, .tx_start_o, .sig_send_o,
    .timeout_o, .port_reset_o, .system_reset_o, .system_clock_request_o,
    .port_clock_select_o, .user_row_commit_o);

  dpcsr_acc_model dpcsr_acc_model_inst (
    .sys_clk_i, .reset_i, .acc_wait_i, .hang_i(hang), .acc_resp_o(acc_resp_i));

  task test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    #1 {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, v};
    @(posedge sys_clk_i);
    #1 reg_wr_i = 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    #1 {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(posedge sys_clk_i);
    #1 reg_rd_i = 1'b0;
    v = reg_rdata_o;
  endtask : rd

  task pulse(input logic [11:0] m);
    @(posedge sys_clk_i);
    #1 pv = m;
    @(posedge sys_clk_i);
    #1 pv = '0;
  endtask : pulse

  // returns lim+1 when the event never showed
  task waitev(input int b, input int lim, output int k);
    k = 0;
    while (ev[b] !== 1'b1 && k <= lim)
    begin
      @(posedge sys_clk_i);
      #1 k++;
    end
  endtask : waitev

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pv, acc_wait_i, hang} = '0;
    {tx_multi_i, ldst_busy_i, sys_asleep_i, sys_in_reset_i, lock_i} = '0;
    {urow_ready_i, prog_ready_i, crc_status_i} = '0;
    reset_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    `CHK({system_clock_request_o, port_clock_select_o, system_reset_o}, 4'hE)
    foreach (rows[i])
      if (rows[i].w)
        wr(rows[i].a, rows[i].v);
      else
      begin
        rd(rows[i].a, d);
        `CHK(d, rows[i].v)
      end
    `CHK({parity_check_disable_o, contention_detect_disable_o}, 2'b01)
    pulse(12'h008);
    rd(4'h1, d);
    `CHK(d, 8'h00)
    wr(4'h3, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      pulse(12'(1 << i));
      rd(4'h1, d);
      `CHK(d, {5'h00, codes[i]})
      rd(4'h1, d);
      `CHK(d, 8'h00)
    end
    pulse(12'h009);
    rd(4'h1, d);
    `CHK(d, 8'h07)
    pulse(12'h070);
    rd(4'h7, d);
    `CHK(d, 8'h38)
    pulse(12'h080);
    rd(4'h7, d);
    `CHK(d, 8'h28)
    pulse(12'h100);
    rd(4'h7, d);
    `CHK(d, 8'h20)
    wr(4'hA, 8'h02);
    `CHK({user_row_commit_o, system_clock_request_o}, 2'b10)
    wr(4'h7, 8'h20);
    rd(4'h7, d);
    `CHK(d, 8'h00)
    {sys_asleep_i, lock_i, urow_ready_i, prog_ready_i, crc_status_i} = 7'h7A;
    rd(4'hB, d);
    `CHK(d, 8'h1D)
    rd(4'hC, d);
    `CHK(d, 8'h02)
    wr(4'h2, 8'h06);
    pulse(12'h400);
    waitev(1, 4, n);
    `CHK(n <= 4, 1'b1)
    wr(4'h2, 8'h0E);
    pulse(12'h400);
    waitev(1, 4, n);
    `CHK(n > 4, 1'b1)
    wr(4'h2, 8'h06);
    wr(4'h3, 8'h10);
    {ldst_busy_i, sys_in_reset_i} = 2'b11;
    repeat (3) @(posedge sys_clk_i);
    pulse(12'h800);
    waitev(1, 4, n);
    `CHK(n > 4, 1'b1)
    {ldst_busy_i, sys_in_reset_i} = 2'b00;
    repeat (3) @(posedge sys_clk_i);
    pulse(12'h800);
    waitev(1, 4, n);
    `CHK(n <= 4, 1'b1)
    wr(4'h3, 8'h00);
    // guard time per code, measured from the edge that takes the request
    for (int g = 0; g < 8; g++)
    begin
      wr(4'h2, 8'(g));
      pulse(12'h200);
      waitev(0, 140, n);
      if (g < 7)
        `CHK(n, (128 >> g) + 2)
      else
        `CHK(n <= 2, 1'b1)
    end
    wr(4'h2, 8'h86);
    tx_multi_i = 1'b1;
    pulse(12'h200);
    waitev(0, 10, n);
    `CHK(n, 4)
    @(posedge sys_clk_i);
    #1 waitev(0, 40, n);
    `CHK(n, 25)
    tx_multi_i = 1'b0;
    acc_wait_i = 1'b1;
    waitev(2, 200, n);
    `CHK(n > 200, 1'b1)
    acc_wait_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1 {hang, acc_wait_i} = 2'b11;
    waitev(2, 65600, n);
    `CHK(n >= 65536 && n <= 65542, 1'b1)
    rd(4'h1, d);
    `CHK(d, 8'h03)
    {hang, acc_wait_i} = 2'b00;
    pulse(12'h070);
    wr(4'hA, 8'h01);
    wr(4'h2, 8'hA0);
    `CHK(parity_check_disable_o, 1'b1)
    pulse(12'h001);
    rd(4'h1, d);
    `CHK(d, 8'h00)
    wr(4'h8, 8'h59);
    `CHK({system_reset_o, system_clock_request_o}, 2'b11)
    wr(4'h3, 8'h04);
    waitev(3, 3, n);
    `CHK(n <= 3, 1'b1)
    rd(4'h2, d);
    `CHK(d, 8'h00)
    rd(4'h7, d);
    `CHK(d, 8'h00)
    `CHK({system_clock_request_o, system_reset_o, port_clock_select_o}, 4'h7)
    wr(4'h8, 8'h00);
    `CHK(system_reset_o, 1'b0)
    // mid-run reset must bring the clock request back after the disable dropped it
    reset_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    `CHK({system_clock_request_o, port_clock_select_o, system_reset_o}, 4'hE)
    test_done();
  end
endmodule : dpcsr_regs_tb
